// ==== core/pmx_pkg.sv ====
// constants and carriers for the parallel-port control pin multiplexer
// assumes a single 200 MHz clock domain and an active-low async reset
package pmx_pkg;

    localparam int NUM_PINS = 3;
    localparam int IDX_OE3 = 0;
    localparam int IDX_HOLD = 1;
    localparam int IDX_ACK = 2;

    // edges after reset release before the synchronised strap is valid
    localparam logic [1:0] STRAP_SETTLE = 2'h2;
    localparam logic [1:0] REL_CNT_RST = 2'h0;

    localparam logic PIN_OUT_RST = 1'h1;
    localparam logic PIN_OE_RST = 1'h0;
    localparam logic ACK_RST = 1'h1;
    localparam logic FLOAT_RST = 1'h0;
    localparam logic XMEM_SEL_RST = 1'h0;
    localparam logic HOLDER_EN_RST = 1'h1;
    localparam logic SYNC_RST = 1'h1;

    typedef struct packed {
        logic out;
        logic oe;
    } pmx_pin_t;

    typedef enum logic [3:0] {
        HS_RUN = 4'h1,
        HS_FLOAT = 4'h2,
        HS_HELD = 4'h4,
        HS_RESUME = 4'h8
    } pmx_hold_st_t;

endpackage

// ==== core/pmx_top.sv ====
// reset-strapped mux of control pins 13..15 with bus hold handshake
// assumes gp and memory-interface inputs come from logic on sys_clk_in;
// pad levels are resolved outside from out/oe
`timescale 1ns/10ps

// Summary of operation
// RL1: pin 13 is gp line 33 with strap low, space-3 sync output-enable when high.
// RL2: pin 14 is gp line 34 with strap low, bus hold request input when high.
// RL3: pin 15 is gp line 35 with strap low, hold acknowledge output when high.
// RL4: chosen pin function takes effect when reset is released.
// RL5: gp lines start as inputs after reset.
// RL6: space-3 output-enable floats in reset, then drives one.
// RL7: space-3 output-enable acts as read enable for synchronous memory such as a fifo.
// RL8: hold acknowledge floats in reset, then drives one.
// RL9: an outside master asserts hold request to take the memory bus.
// RL10: on hold request, memory lines float first, then acknowledge asserts.
// RL11: memory-interface pins float while in the hold state.
// RL12: reset-floating pins stay floating as long as reset is low.
// RL13: control pins have a bus holder, enabled by default, controlled from bus control register.
// RL14: strap latched at reset release and kept until the next reset.
// RL15: acknowledge is active low; returns high after request gone and lines driven again.
module pmx_top (
    input wire logic sys_clk_in,
    input wire logic nrst_in,
    input wire logic mux_strap_pin_in,
    input wire logic ctl_pin_13_in,
    input wire logic ctl_pin_14_in,
    input wire logic ctl_pin_15_in,
    output logic ctl_pin_13_out,
    output logic ctl_pin_13_oe_out,
    output logic ctl_pin_14_out,
    output logic ctl_pin_14_oe_out,
    output logic ctl_pin_15_out,
    output logic ctl_pin_15_oe_out,
    input wire logic [2:0] par_gp_out_in,
    input wire logic [2:0] par_gp_dir_in,
    output logic [2:0] par_gp_in_out,
    input wire logic sync_out_enable_space3_in,
    input wire logic xmem_idle_in,
    output logic mem_float_out,
    output logic xmem_mode_out,
    output logic mode_valid_out,
    input wire logic holder_en_in,
    output logic [2:0] bus_holder_en_out
);

    ////////////////////////////////////////////////////////////////////////
    // pin and strap synchronisers

    logic [2:0] pin_raw;
    logic [2:0] pin_s1_q;
    logic [2:0] pin_s2_q;
    logic strap_s1_q;
    logic strap_s2_q;

    assign pin_raw = {ctl_pin_15_in, ctl_pin_14_in, ctl_pin_13_in};

    genvar gi;
    generate
        for (gi = 0; gi < pmx_pkg::NUM_PINS; gi++) begin : g_sync
            always_ff @(posedge sys_clk_in or negedge nrst_in) begin
                if (!nrst_in) begin
                    pin_s1_q[gi] <= pmx_pkg::SYNC_RST;
                    pin_s2_q[gi] <= pmx_pkg::SYNC_RST;
                end else begin
                    pin_s1_q[gi] <= pin_raw[gi];
                    pin_s2_q[gi] <= pin_s1_q[gi];
                end
            end
        end
    endgenerate

    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            strap_s1_q <= pmx_pkg::XMEM_SEL_RST;
            strap_s2_q <= pmx_pkg::XMEM_SEL_RST;
        end else begin
            strap_s1_q <= mux_strap_pin_in;
            strap_s2_q <= strap_s1_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // strap capture after release

    logic [1:0] rel_q;
    logic [1:0] rel_d;
    logic valid_q;
    logic xmem_sel_q;
    logic capture;

    assign capture = (rel_q == pmx_pkg::STRAP_SETTLE) && !valid_q;
    assign rel_d = (rel_q == pmx_pkg::STRAP_SETTLE) ? rel_q : rel_q + 2'h1;

    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            rel_q <= pmx_pkg::REL_CNT_RST;
            valid_q <= 1'b0;
            xmem_sel_q <= pmx_pkg::XMEM_SEL_RST;
        end else begin
            rel_q <= rel_d;
            if (capture) begin
                valid_q <= 1'b1; // RL4
                xmem_sel_q <= strap_s2_q; // RL14
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // bus hold handshake

    pmx_pkg::pmx_hold_st_t st_q;
    pmx_pkg::pmx_hold_st_t st_d;
    logic float_q;
    logic float_d;
    logic ack_q;
    logic ack_d;
    logic hold_req;

    // request is active low on pin 14
    assign hold_req = valid_q && xmem_sel_q && !pin_s2_q[pmx_pkg::IDX_HOLD]; // RL2 RL9

    always_comb begin
        st_d = st_q;
        float_d = float_q;
        ack_d = ack_q;
        case (st_q)
            pmx_pkg::HS_RUN: begin
                if (hold_req && xmem_idle_in) begin
                    st_d = pmx_pkg::HS_FLOAT;
                    float_d = 1'b1; // RL10
                end
            end
            pmx_pkg::HS_FLOAT: begin
                st_d = pmx_pkg::HS_HELD;
                ack_d = 1'b0; // RL10 RL15
            end
            pmx_pkg::HS_HELD: begin
                if (!hold_req) begin
                    st_d = pmx_pkg::HS_RESUME;
                    float_d = 1'b0;
                end
            end
            pmx_pkg::HS_RESUME: begin
                st_d = pmx_pkg::HS_RUN;
                ack_d = 1'b1; // RL15
            end
            default: begin
                st_d = pmx_pkg::HS_RUN;
                float_d = pmx_pkg::FLOAT_RST;
                ack_d = pmx_pkg::ACK_RST;
            end
        endcase
    end

    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            st_q <= pmx_pkg::HS_RUN;
            float_q <= pmx_pkg::FLOAT_RST;
            ack_q <= pmx_pkg::ACK_RST;
        end else begin
            st_q <= st_d;
            float_q <= float_d;
            ack_q <= ack_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pin drive selection

    pmx_pkg::pmx_pin_t [2:0] pin_q;
    pmx_pkg::pmx_pin_t [2:0] pin_d;
    logic [2:0] gp_oe;
    logic [2:0] holder_q;

    assign gp_oe = par_gp_dir_in & {3{valid_q && !xmem_sel_q}}; // RL5 RL12

    // space-3 enable forced high on its first driven cycle; read enable for sync memory
    assign pin_d[0].out = xmem_sel_q
        ? (sync_out_enable_space3_in || !pin_q[0].oe) // RL6 RL7
        : par_gp_out_in[0];
    assign pin_d[0].oe = xmem_sel_q ? (valid_q && !float_q) : gp_oe[0]; // RL1 RL11
    assign pin_d[1].out = par_gp_out_in[1];
    assign pin_d[1].oe = gp_oe[1]; // RL2
    assign pin_d[2].out = xmem_sel_q ? ack_q : par_gp_out_in[2]; // RL8
    assign pin_d[2].oe = xmem_sel_q ? valid_q : gp_oe[2]; // RL3

    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            for (int i = 0; i < pmx_pkg::NUM_PINS; i++) begin
                pin_q[i].out <= pmx_pkg::PIN_OUT_RST;
                pin_q[i].oe <= pmx_pkg::PIN_OE_RST; // RL12
            end
            holder_q <= {3{pmx_pkg::HOLDER_EN_RST}};
        end else begin
            pin_q <= pin_d;
            holder_q <= valid_q ? {3{holder_en_in}} : {3{pmx_pkg::HOLDER_EN_RST}}; // RL13
        end
    end

    assign ctl_pin_13_out = pin_q[0].out;
    assign ctl_pin_13_oe_out = pin_q[0].oe;
    assign ctl_pin_14_out = pin_q[1].out;
    assign ctl_pin_14_oe_out = pin_q[1].oe;
    assign ctl_pin_15_out = pin_q[2].out;
    assign ctl_pin_15_oe_out = pin_q[2].oe;
    assign par_gp_in_out = pin_s2_q;
    assign mem_float_out = float_q;
    assign xmem_mode_out = xmem_sel_q;
    assign mode_valid_out = valid_q;
    assign bus_holder_en_out = holder_q;

    ////////////////////////////////////////////////////////////////////////
    // checks

    chk_float_unsel: assert property (@(posedge sys_clk_in) disable iff (!nrst_in) // RL12
        !valid_q |-> !(ctl_pin_13_oe_out || ctl_pin_14_oe_out || ctl_pin_15_oe_out))
        else $error("pin driven before mode selected");

    chk_gp_input_start: assert property (@(posedge sys_clk_in) disable iff (!nrst_in) // RL5
        $rose(valid_q) |-> !(ctl_pin_13_oe_out || ctl_pin_14_oe_out || ctl_pin_15_oe_out))
        else $error("pin driven in first selected cycle");

    chk_strap_kept: assert property (@(posedge sys_clk_in) disable iff (!nrst_in) // RL14
        $past(valid_q) |-> $stable(xmem_sel_q))
        else $error("pin function changed after capture");

    chk_oe3_first_one: assert property (@(posedge sys_clk_in) disable iff (!nrst_in) // RL6
        ($rose(valid_q) && xmem_sel_q) |=> (ctl_pin_13_oe_out && ctl_pin_13_out))
        else $error("space-3 enable not driven high after reset");

    chk_ack_first_one: assert property (@(posedge sys_clk_in) disable iff (!nrst_in) // RL8
        ($rose(valid_q) && xmem_sel_q) |=> (ctl_pin_15_oe_out && ctl_pin_15_out))
        else $error("hold acknowledge not driven high after reset");

    chk_hold_pin_input: assert property (@(posedge sys_clk_in) disable iff (!nrst_in) // RL2
        xmem_sel_q |-> !ctl_pin_14_oe_out)
        else $error("hold request pin driven");

    chk_float_before_ack: assert property (@(posedge sys_clk_in) disable iff (!nrst_in) // RL10
        $fell(ack_q) |-> (float_q && $past(float_q)))
        else $error("acknowledge before lines floated");

    chk_hold_response: assert property (@(posedge sys_clk_in) disable iff (!nrst_in) // RL10
        (st_q == pmx_pkg::HS_RUN && hold_req && xmem_idle_in)
        |=> (st_q == pmx_pkg::HS_FLOAT) ##1 (st_q == pmx_pkg::HS_HELD) ##1 !ctl_pin_15_out)
        else $error("hold request not acknowledged in three cycles");

    chk_held_float: assert property (@(posedge sys_clk_in) disable iff (!nrst_in) // RL11
        (st_q == pmx_pkg::HS_HELD && $past(st_q) == pmx_pkg::HS_HELD) |-> !ctl_pin_13_oe_out)
        else $error("space-3 enable driven while held");

    chk_ack_release: assert property (@(posedge sys_clk_in) disable iff (!nrst_in) // RL15
        $rose(ack_q) |-> (!float_q && !hold_req && !$past(float_q)))
        else $error("acknowledge released early");

    chk_holder_default: assert property (@(posedge sys_clk_in) disable iff (!nrst_in) // RL13
        !valid_q |-> (&bus_holder_en_out))
        else $error("bus holder off by default");

    cov_hold_entered: cover property (@(posedge sys_clk_in) disable iff (!nrst_in)
        st_q == pmx_pkg::HS_HELD && !ctl_pin_15_out);

    cov_hold_resumed: cover property (@(posedge sys_clk_in) disable iff (!nrst_in)
        st_q == pmx_pkg::HS_RESUME ##1 st_q == pmx_pkg::HS_RUN);

    cov_gp_mode: cover property (@(posedge sys_clk_in) disable iff (!nrst_in)
        valid_q && !xmem_sel_q && ctl_pin_13_oe_out);

endmodule

// ==== core/pmx_dummy_unused.sv ====
// spare file of the control pin multiplexer; all of its logic sits in pmx_top
// assumes nothing of its surroundings

// ==== bench/pmx_host_model.sv ====
// bench model of an outside master that wants the memory bus
// assumes pin 14 pad is fed from hold_n_out while the device leaves it floating
`timescale 1ns/10ps
module pmx_host_model (
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic want_in,
    input wire logic ack_n_in,
    output logic hold_n_out,
    output logic granted_out
);
    // request is active low and changes only just after a clock edge
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            hold_n_out <= 1'h1;
        end else begin
            hold_n_out <= ~want_in;
        end
    end
    assign granted_out = ~hold_n_out & ~ack_n_in;
endmodule

// ==== bench/parallel_port_ctl_pin_mux_test.sv ====
// self-checking bench for the control pin multiplexer
// assumes pads resolve from out/oe, with the bench or the host model driving floating pins
`timescale 1ns/10ps
module parallel_port_ctl_pin_mux_test;
    logic clk = 1'h0;
    logic nrst = 1'h0;
    logic strap = 1'h0;
    logic hostc = 1'h0;
    logic oe3 = 1'h1;
    logic idle = 1'h1;
    logic hen = 1'h1;
    logic want = 1'h0;
    logic [2:0] gout = 3'h0;
    logic [2:0] gdir = 3'h0;
    logic [2:0] ext = 3'h7;
    logic [2:0] po, poe, gin, hen_o, pad, exp_pad;
    logic mfl, mode, mvld, hold_n, granted;
    int failures = 0;
    int cmp_count = 0;
    int unsigned rng = 8277;
    int k;
    always #2.5 clk = ~clk;
    ////////////////////////////////////////////////////////////////
    assign pad[0] = poe[0] ? po[0] : ext[0];
    assign pad[1] = poe[1] ? po[1] : (hostc ? hold_n : ext[1]);
    assign pad[2] = poe[2] ? po[2] : ext[2];
    pmx_top pmx_top_i (.sys_clk_in(clk), .nrst_in(nrst), .mux_strap_pin_in(strap),
        .ctl_pin_13_in(pad[0]), .ctl_pin_14_in(pad[1]), .ctl_pin_15_in(pad[2]),
        .ctl_pin_13_out(po[0]), .ctl_pin_13_oe_out(poe[0]), .ctl_pin_14_out(po[1]),
        .ctl_pin_14_oe_out(poe[1]), .ctl_pin_15_out(po[2]), .ctl_pin_15_oe_out(poe[2]),
        .par_gp_out_in(gout), .par_gp_dir_in(gdir), .par_gp_in_out(gin),
        .sync_out_enable_space3_in(oe3), .xmem_idle_in(idle), .mem_float_out(mfl),
        .xmem_mode_out(mode), .mode_valid_out(mvld), .holder_en_in(hen), .bus_holder_en_out(hen_o));
    pmx_host_model pmx_host_model_i (.clk_in(clk), .nrst_in(nrst), .want_in(want),
        .ack_n_in(po[2]), .hold_n_out(hold_n), .granted_out(granted));
    ////////////////////////////////////////////////////////////////
    function automatic logic [2:0] xs3();
        rng ^= rng << 13;
        rng ^= rng >> 17;
        rng ^= rng << 5;
        return rng[2:0];
    endfunction
    task automatic chk(input logic [3:0] got, input logic [3:0] exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %0t %s: got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wrap_up();
        $display("counts: %0d compares, %0d failures", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic start(input logic s);
        @(posedge clk);
        nrst <= 1'h0;
        strap <= s;
        hostc <= s;
        gdir <= 3'h0;
        tick(2);
        chk(4'(poe), 4'h0, "oe in reset");
        chk(4'(gin), 4'h7, "gp inputs in reset");
        chk(4'(hen_o), 4'h7, "holder default");
        chk(4'(mvld), 4'h0, "mode invalid in reset");
        tick(8);
        @(posedge clk);
        nrst <= 1'h1;
        tick(6);
        chk(4'(mvld), 4'h1, "mode valid");
        chk(4'(mode), 4'(s), "mode latched");
    endtask
    task automatic wait_ack(input logic v);
        for (int i = 0; i < 40 && po[2] !== v; i++) begin
            tick(1);
        end
        chk(4'(po[2]), 4'(v), "ack level");
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        #100000;
        failures++;
        $display("ERROR %0t watchdog expired", $time);
        wrap_up();
    end
    initial begin
        start(1'h0);
        chk(4'(poe), 4'h0, "gp lines are inputs");
        for (k = 0; k < 16; k++) begin
            @(posedge clk);
            gdir <= xs3();
            gout <= xs3();
            ext <= xs3();
            hen <= xs3() > 3'h3;
            strap <= xs3() > 3'h3;
            tick(4);
            exp_pad = (gdir & gout) | (~gdir & ext);
            chk(4'(poe), 4'(gdir), "gp direction");
            chk(4'(gin), 4'(exp_pad), "gp pad levels");
            chk(4'(hen_o), {1'h0, {3{hen}}}, "holder follows enable");
            chk(4'(mode), 4'h0, "mode kept");
        end
        $display("gp mode test done");
        start(1'h1);
        chk(4'(poe), 4'h5, "memory mode drive");
        chk(4'({po[2], po[0]}), 4'h3, "memory outputs high");
        @(posedge clk);
        gdir <= 3'h7;
        oe3 <= 1'h0;
        tick(3);
        chk(4'(po[0]), 4'h0, "space3 enable follows");
        chk(4'(poe), 4'h5, "gp ignored, hold pin input");
        @(posedge clk);
        oe3 <= 1'h1;
        idle <= 1'h0;
        want <= 1'h1;
        tick(10);
        chk(4'({mfl, po[2]}), 4'h1, "hold waits for idle");
        @(posedge clk);
        idle <= 1'h1;
        wait_ack(1'h0);
        chk(4'({mfl, poe[0], granted}), 4'h5, "lines float in hold");
        @(posedge clk);
        want <= 1'h0;
        wait_ack(1'h1);
        chk(4'({mfl, poe[0]}), 4'h1, "lines driven after hold");
        $display("memory mode test done");
        start(1'h0);
        chk(4'(poe), 4'h0, "gp mode after second reset");
        $display("second reset test done");
        wrap_up();
    end
endmodule
